//--- hw/scp_regs.svh
// Register offsets, field positions, reset values and timing counts of the configuration bank.
// Functional notes
// - Two-bit divider code selects divide by 1, 2, 4 or 8; resets to 0.
// - Bit 7 enables the peripheral subsystem clock; off after reset.
// - Sixteen pad driver bits: 0 open-drain, 1 push-pull; reset all zeros.
// - SPI routing bit 16 connects SPI to pads, removing plain GPIO use.
// - SPI routing bit 17 chooses one of two SPI pad sets.
// - USART routing bit 18 connects the USART to pads, removing plain GPIO use.
// - USART routing bits 20:19 choose one of four transmit/receive pad sets.
// - USART receive pad is always open-drain regardless of driver bits.
// - I2C routing bits 23:21: enable in low bit, pad set in upper two.
// - Both I2C pads are always open-drain regardless of driver bits.
// - Bit 30 ties the LIN transceiver transmit and receive lines to pads.
// - Bit 31 mirrors flash main area (0) or RAM (1) at address zero.
// - Bits 29:24 of the port configuration register read as zero.
// - Bits 7:0 give program section first page; all ones before loading.
// - Bits 15:8 give log section first page; all ones before loading.
// - Bits 26:16 give first debug-accessible RAM word; reset all ones.
// - Bits 31:28 report key lock, permanent lock and failed unlock count.
// - SPI set 0 uses pads 0,1,2,3; set 1 uses pads 9,10,11,12.
// - USART sets map transmit/receive to pads 4/8, 2/3, 6/7, 9/10.
// - I2C sets map to pads 11/12, 0/1, 4/5, 14/15; LIN uses 4 and 2.
// - Pad priority: LIN test, I2C, USART, SPI, then plain GPIO.
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

`define SCP_ADDR_CLOCK_CONFIGURATION   32'h4000_0000
`define SCP_ADDR_MEMORY_AND_PORT_CFG   32'h4000_0004
`define SCP_ADDR_MEMORY_PARTITION_INFO 32'h4000_0008

`define SCP_CLK_DIV_LSB       0
`define SCP_CLK_GATE_BIT      7
`define SCP_DRIVER_LSB        0
`define SCP_SPI_LSB           16
`define SCP_USART_LSB         18
`define SCP_I2C_LSB           21
`define SCP_LIN_TEST_BIT      30
`define SCP_BOOT_SEL_BIT      31

`define SCP_PROG_PAGE_LSB     0
`define SCP_LOG_PAGE_LSB      8
`define SCP_RAM_BOUND_LSB     16
`define SCP_PROT_LSB          28

`define SCP_RST_PAGE          8'hFF
`define SCP_RST_RAM_BOUND     11'h7FF
`define SCP_RST_PROT          4'hF
`define SCP_RST_DIV           2'h0
`define SCP_DIV_MAX_COUNT     3'h7

`endif

//--- hw/scp_pkg.sv
// Types shared by the configuration bank.
package scp_pkg;

  typedef struct packed {
    logic [3:0]  protection_scheme;
    logic [10:0] debug_ram_boundary;
    logic [7:0]  log_section_first_page;
    logic [7:0]  program_section_first_page;
  } scp_meminfo_s;

  typedef struct packed {
    logic        spi_csn;
    logic        spi_mosi;
    logic        spi_sclk;
    logic        usart_txd;
    logic        i2c_scl_low;
    logic        i2c_sda_low;
    logic        lin_txd;
  } scp_periph_out_s;

  typedef struct packed {
    logic        spi_miso;
    logic        usart_rxd;
    logic        i2c_scl;
    logic        i2c_sda;
    logic        lin_rxd;
  } scp_periph_in_s;

  typedef enum logic [2:0] {
    SCP_OWN_GPIO,
    SCP_OWN_SPI,
    SCP_OWN_USART,
    SCP_OWN_I2C,
    SCP_OWN_LIN
  } scp_owner_e;

endpackage : scp_pkg

//--- hw/scp_config_bank.sv
// System configuration bank: clock divider, pad routing and memory information.
`timescale 1ns/1ps
`include "scp_regs.svh"

module scp_config_bank #(
  parameter int NUM_PADS = 16
) (
  // APB clock and reset.
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Clock control and boot memory select.
  output logic                               sys_clk_enable,
  output logic                               subsystem_clock_gate,
  output logic                               boot_memory_select,
  // Flash controller load port.
  input  wire logic                          meminfo_load,
  input  wire scp_pkg::scp_meminfo_s         meminfo_data,
  // Peripherals.
  input  wire scp_pkg::scp_periph_out_s      periph_out,
  output scp_pkg::scp_periph_in_s            periph_in,
  // GPIO module.
  input  wire logic [NUM_PADS-1:0]           gpio_out,
  input  wire logic [NUM_PADS-1:0]           gpio_drive,
  output logic      [NUM_PADS-1:0]           gpio_in,
  // Pads.
  input  wire logic [NUM_PADS-1:0]           pad_in,
  output logic      [NUM_PADS-1:0]           pad_out,
  output logic      [NUM_PADS-1:0]           pad_oe_n
);

  logic [1:0]              clock_divider_select;
  logic [NUM_PADS-1:0]     pad_driver_type_bits;
  logic [1:0]              spi_pad_routing;
  logic [2:0]              serial_port_pad_routing;
  logic [2:0]              two_wire_pad_routing;
  logic                    transceiver_test_bypass;
  scp_pkg::scp_meminfo_s   meminfo;
  logic [2:0]              div_count;
  logic [NUM_PADS-1:0]     pad_sync1;
  logic [NUM_PADS-1:0]     pad_sync2;
  scp_pkg::scp_owner_e     owner [NUM_PADS];
  logic [31:0]             next_prdata;
  logic                    wr_en;
  logic                    rd_en;
  logic                    hit_clk;
  logic                    hit_port;
  logic                    hit_info;

  assign hit_clk  = (paddr == `SCP_ADDR_CLOCK_CONFIGURATION);
  assign hit_port = (paddr == `SCP_ADDR_MEMORY_AND_PORT_CFG);
  assign hit_info = (paddr == `SCP_ADDR_MEMORY_PARTITION_INFO);
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && penable && !pwrite;
  assign pready   = 1'b1;

  // Writes to the read-only bank or unmapped addresses answer with an error.
  assign pslverr  = psel && penable && !(hit_clk || hit_port || (hit_info && !pwrite));

  // Clock configuration; unused bits are not stored and read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider_select <= `SCP_RST_DIV;
      subsystem_clock_gate <= 1'b0;
    end else if (wr_en && hit_clk && pstrb[0]) begin
      clock_divider_select <= pwdata[`SCP_CLK_DIV_LSB +: 2];
      subsystem_clock_gate <= pwdata[`SCP_CLK_GATE_BIT];
    end
  end

  // Memory and port configuration, byte lane by byte lane.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_driver_type_bits    <= '0;
      spi_pad_routing         <= 2'h0;
      serial_port_pad_routing <= 3'h0;
      two_wire_pad_routing    <= 3'h0;
      transceiver_test_bypass <= 1'b0;
      boot_memory_select      <= 1'b0;
    end else if (wr_en && hit_port) begin
      if (pstrb[0]) begin
        pad_driver_type_bits[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        pad_driver_type_bits[NUM_PADS-1:8] <= pwdata[NUM_PADS-1:8];
      end
      if (pstrb[2]) begin
        spi_pad_routing         <= pwdata[`SCP_SPI_LSB +: 2];
        serial_port_pad_routing <= pwdata[`SCP_USART_LSB +: 3];
        two_wire_pad_routing    <= pwdata[`SCP_I2C_LSB +: 3];
      end
      if (pstrb[3]) begin
        transceiver_test_bypass <= pwdata[`SCP_LIN_TEST_BIT];
        boot_memory_select      <= pwdata[`SCP_BOOT_SEL_BIT];
      end
    end
  end

  // Memory information holds between flash loads.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meminfo.program_section_first_page <= `SCP_RST_PAGE;
      meminfo.log_section_first_page     <= `SCP_RST_PAGE;
      meminfo.debug_ram_boundary         <= `SCP_RST_RAM_BOUND;
      meminfo.protection_scheme          <= `SCP_RST_PROT;
    end else if (meminfo_load) begin
      meminfo <= meminfo_data;
    end
  end

  // Clock divider: one-cycle enable every 1, 2, 4 or 8 cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 3'h0;
    end else if (sys_clk_enable) begin
      div_count <= 3'h0;
    end else begin
      div_count <= div_count + 3'h1;
    end
  end

  always_comb begin
    sys_clk_enable = (div_count >= (`SCP_DIV_MAX_COUNT >> (3'h3 - {1'b0, clock_divider_select})));
  end

  // Register read data.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_clk) begin
      next_prdata[`SCP_CLK_DIV_LSB +: 2] = clock_divider_select;
      next_prdata[`SCP_CLK_GATE_BIT]     = subsystem_clock_gate;
    end else if (hit_port) begin
      next_prdata[NUM_PADS-1:0]            = pad_driver_type_bits;
      next_prdata[`SCP_SPI_LSB +: 2]       = spi_pad_routing;
      next_prdata[`SCP_USART_LSB +: 3]     = serial_port_pad_routing;
      next_prdata[`SCP_I2C_LSB +: 3]       = two_wire_pad_routing;
      next_prdata[`SCP_LIN_TEST_BIT]       = transceiver_test_bypass;
      next_prdata[`SCP_BOOT_SEL_BIT]       = boot_memory_select;
    end else if (hit_info) begin
      next_prdata[`SCP_PROG_PAGE_LSB +: 8] = meminfo.program_section_first_page;
      next_prdata[`SCP_LOG_PAGE_LSB +: 8]  = meminfo.log_section_first_page;
      next_prdata[`SCP_RAM_BOUND_LSB +: 11] = meminfo.debug_ram_boundary;
      next_prdata[`SCP_PROT_LSB +: 4]      = meminfo.protection_scheme;
    end
  end

  // Read data is registered in the setup cycle and valid in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Pad inputs pass two flip-flops before any logic reads them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_sync1 <= '0;
      pad_sync2 <= '0;
    end else begin
      pad_sync1 <= pad_in;
      pad_sync2 <= pad_sync1;
    end
  end

  // Pad ownership by fixed priority, lowest first so higher ones overwrite.
  always_comb begin
    for (int p = 0; p < NUM_PADS; p++) begin
      owner[p] = scp_pkg::SCP_OWN_GPIO;
    end
    if (spi_pad_routing[0]) begin
      if (!spi_pad_routing[1]) begin
        for (int p = 0; p < 4; p++) owner[p] = scp_pkg::SCP_OWN_SPI;
      end else begin
        for (int p = 9; p < 13; p++) owner[p] = scp_pkg::SCP_OWN_SPI;
      end
    end
    if (serial_port_pad_routing[0]) begin
      case (serial_port_pad_routing[2:1])
        2'h0: begin owner[4] = scp_pkg::SCP_OWN_USART; owner[8]  = scp_pkg::SCP_OWN_USART; end
        2'h1: begin owner[2] = scp_pkg::SCP_OWN_USART; owner[3]  = scp_pkg::SCP_OWN_USART; end
        2'h2: begin owner[6] = scp_pkg::SCP_OWN_USART; owner[7]  = scp_pkg::SCP_OWN_USART; end
        default: begin owner[9] = scp_pkg::SCP_OWN_USART; owner[10] = scp_pkg::SCP_OWN_USART; end
      endcase
    end
    if (two_wire_pad_routing[0]) begin
      case (two_wire_pad_routing[2:1])
        2'h0: begin owner[11] = scp_pkg::SCP_OWN_I2C; owner[12] = scp_pkg::SCP_OWN_I2C; end
        2'h1: begin owner[0]  = scp_pkg::SCP_OWN_I2C; owner[1]  = scp_pkg::SCP_OWN_I2C; end
        2'h2: begin owner[4]  = scp_pkg::SCP_OWN_I2C; owner[5]  = scp_pkg::SCP_OWN_I2C; end
        default: begin owner[14] = scp_pkg::SCP_OWN_I2C; owner[15] = scp_pkg::SCP_OWN_I2C; end
      endcase
    end
    if (transceiver_test_bypass) begin
      owner[4] = scp_pkg::SCP_OWN_LIN;
      owner[2] = scp_pkg::SCP_OWN_LIN;
    end
  end

  // Pad drive. An open-drain pad only enables its driver to pull low.
  always_comb begin
    logic pp;
    logic val;
    logic drv;
    pp  = 1'b0;
    val = 1'b0;
    drv = 1'b0;
    for (int p = 0; p < NUM_PADS; p++) begin
      pp  = pad_driver_type_bits[p];
      val = 1'b0;
      drv = 1'b0;
      case (owner[p])
        scp_pkg::SCP_OWN_SPI: begin
          drv = (p != 2) && (p != 11);
          val = (p == 0 || p == 9)  ? periph_out.spi_csn  :
                (p == 1 || p == 10) ? periph_out.spi_mosi : periph_out.spi_sclk;
        end
        scp_pkg::SCP_OWN_USART: begin
          // Pins 8, 3, 7, 10 carry receive: open-drain, released high.
          if (p == 8 || p == 3 || p == 7 || p == 10) begin
            pp  = 1'b0;
            val = 1'b1;
          end else begin
            val = periph_out.usart_txd;
          end
          drv = 1'b1;
        end
        scp_pkg::SCP_OWN_I2C: begin
          pp  = 1'b0;
          drv = 1'b1;
          val = (p == 11 || p == 0 || p == 4 || p == 14) ?
                !periph_out.i2c_scl_low : !periph_out.i2c_sda_low;
        end
        scp_pkg::SCP_OWN_LIN: begin
          drv = (p == 4);
          val = periph_out.lin_txd;
        end
        scp_pkg::SCP_OWN_GPIO: begin
          drv = gpio_drive[p];
          val = gpio_out[p];
        end
        default: begin
          drv = 1'b0;
        end
      endcase
      pad_out[p]  = val;
      pad_oe_n[p] = !(drv && (pp || !val));
    end
  end

  // Inputs back to peripherals and GPIO.
  always_comb begin
    periph_in = '{spi_miso: 1'b1, usart_rxd: 1'b1, i2c_scl: 1'b1, i2c_sda: 1'b1, lin_rxd: 1'b1};
    for (int p = 0; p < NUM_PADS; p++) begin
      gpio_in[p] = (owner[p] == scp_pkg::SCP_OWN_GPIO) ? pad_sync2[p] : 1'b0;
      if (owner[p] == scp_pkg::SCP_OWN_SPI && (p == 2 || p == 11)) begin
        periph_in.spi_miso = pad_sync2[p];
      end
      if (owner[p] == scp_pkg::SCP_OWN_USART && (p == 8 || p == 3 || p == 7 || p == 10)) begin
        periph_in.usart_rxd = pad_sync2[p];
      end
      if (owner[p] == scp_pkg::SCP_OWN_I2C) begin
        if (p == 11 || p == 0 || p == 4 || p == 14) begin
          periph_in.i2c_scl = pad_sync2[p];
        end else begin
          periph_in.i2c_sda = pad_sync2[p];
        end
      end
      if (owner[p] == scp_pkg::SCP_OWN_LIN && p == 2) begin
        periph_in.lin_rxd = pad_sync2[p];
      end
    end
  end

endmodule : scp_config_bank

//--- sim/scp_config_bank_assertions.sv
// Port checker for the configuration bank, bound to the design top.
`timescale 1ns/1ps
module scp_config_bank_assertions #(
  parameter int NUM_PADS = 16
) (
  // APB side.
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [31:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [3:0]               pstrb,
  input wire logic [31:0]              prdata,
  input wire logic                     pslverr,
  // Controls and pads.
  input wire logic                     sys_clk_enable,
  input wire logic                     subsystem_clock_gate,
  input wire logic                     boot_memory_select,
  input wire scp_pkg::scp_periph_out_s periph_out,
  input wire logic [NUM_PADS-1:0]      gpio_out,
  input wire logic [NUM_PADS-1:0]      gpio_drive,
  input wire logic [NUM_PADS-1:0]      pad_oe_n
);
  logic [31:0] cfg_clk;
  logic [31:0] cfg_port;
  logic        wr_acc;
  assign wr_acc = psel && penable && pwrite;

  // Shadow copies of the two writable registers, built from the bus alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_clk  <= 32'h0;
      cfg_port <= 32'h0;
    end else if (wr_acc) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b] && paddr == 32'h4000_0000) cfg_clk[8*b+:8] <= pwdata[8*b+:8];
        if (pstrb[b] && paddr == 32'h4000_0004) cfg_port[8*b+:8] <= pwdata[8*b+:8];
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence info_read;
    psel && !penable && !pwrite && paddr == 32'h4000_0008 ##1 psel && penable;
  endsequence

  a_gate_write: assert property (wr_acc && pstrb[0] && paddr == 32'h4000_0000 |=>
    subsystem_clock_gate == $past(pwdata[7])) else $error("clock gate missed write");
  a_boot_write: assert property (wr_acc && pstrb[3] && paddr == 32'h4000_0004 |=>
    boot_memory_select == $past(pwdata[31])) else $error("boot select missed write");
  a_boot_hold: assert property (!(wr_acc && pstrb[3] && paddr == 32'h4000_0004) |=>
    $stable(boot_memory_select)) else $error("boot select changed without write");
  a_div_fast: assert property ((cfg_clk[1:0] == 2'h0) [*2] |-> sys_clk_enable)
    else $error("divide by one lost a pulse");
  a_div_bound: assert property (sys_clk_enable |-> ##[1:8] sys_clk_enable)
    else $error("divider pulse gap above eight");
  a_info_ro: assert property (wr_acc && paddr == 32'h4000_0008 |-> pslverr)
    else $error("info write not refused");
  a_info_bit27: assert property (info_read |-> !prdata[27])
    else $error("info bit 27 read as one");
  a_i2c_od: assert property (cfg_port[23:21] == 3'b011 && !cfg_port[30] |->
    pad_oe_n[0] == !periph_out.i2c_scl_low) else $error("clock line not open drain");
  a_gpio_drv: assert property (cfg_port[23:16] == 8'h0 && !cfg_port[30] |->
    pad_oe_n == ~(gpio_drive & (cfg_port[15:0] | ~gpio_out))) else $error("pad driver wrong");
endmodule : scp_config_bank_assertions

bind scp_config_bank scp_config_bank_assertions #(.NUM_PADS(NUM_PADS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .sys_clk_enable(sys_clk_enable), .subsystem_clock_gate(subsystem_clock_gate),
  .boot_memory_select(boot_memory_select), .periph_out(periph_out), .gpio_out(gpio_out),
  .gpio_drive(gpio_drive), .pad_oe_n(pad_oe_n)
);

//--- sim/system_config_pinmux_meminfo_test.sv
// Self-checking bench for the configuration bank.
`timescale 1ns/1ps
module system_config_pinmux_meminfo_test;
  localparam logic [31:0] A_CLK  = 32'h4000_0000;
  localparam logic [31:0] A_PORT = 32'h4000_0004;
  localparam logic [31:0] A_INFO = 32'h4000_0008;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0]              paddr, pwdata, prdata, rd;
  logic [3:0]               pstrb;
  logic                     sys_clk_enable, subsystem_clock_gate, boot_memory_select;
  logic                     meminfo_load;
  logic [15:0]              gpio_out, gpio_drive, gpio_in, pad_in, pad_out, pad_oe_n;
  scp_pkg::scp_meminfo_s    meminfo_data;
  scp_pkg::scp_periph_out_s periph_out;
  scp_pkg::scp_periph_in_s  periph_in;
  int                       n_fail = 0, n_compared = 0, cycles = 0, n;
  int                       tx[4] = '{4, 2, 6, 9}, rx[4] = '{8, 3, 7, 10};
  int                       scl[4] = '{11, 0, 4, 14}, sda[4] = '{12, 1, 5, 15};

  scp_config_bank DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_clk_enable(sys_clk_enable),
    .subsystem_clock_gate(subsystem_clock_gate), .boot_memory_select(boot_memory_select),
    .meminfo_load(meminfo_load), .meminfo_data(meminfo_data), .periph_out(periph_out),
    .periph_in(periph_in), .gpio_out(gpio_out), .gpio_drive(gpio_drive), .gpio_in(gpio_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n)
  );

  always #5 pclk = ~pclk;

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; returns at the following falling edge so outputs have settled.
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask : rd_chk

  // Cycles between two divider pulses, counted from the first pulse seen.
  task automatic period(output int p);
    p = 0;
    while (sys_clk_enable !== 1'b1) @(negedge pclk);
    do begin
      @(negedge pclk);
      p++;
    end while (sys_clk_enable !== 1'b1);
  endtask : period

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 0; meminfo_load = 0; meminfo_data = '0; gpio_out = 16'h00F0;
    gpio_drive = 16'hFFFF; pad_in = 16'hFFFB;
    periph_out = 7'b1011101;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_CLK, 32'h0);
    rd_chk(A_PORT, 32'h0);
    rd_chk(A_INFO, 32'hF7FF_FFFF);
    chk(pad_oe_n, 16'h00F0);
    chk({subsystem_clock_gate, boot_memory_select}, 0);
    for (int i = 0; i < 4; i++) begin
      wr(A_CLK, {24'h0, 1'b1, 5'h0, 2'(i)});
      period(n);
      chk(n, 1 << i);
    end
    rd_chk(A_CLK, 32'h83);
    chk(subsystem_clock_gate, 1);
    wr(A_PORT, 32'h0000_FFFF);
    chk(pad_oe_n, 16'h0);
    chk(pad_out, gpio_out);
    apb(1'b1, A_PORT, 32'hFFA4_0000, 4'hC);
    rd_chk(A_PORT, 32'hC0A4_FFFF);
    chk(boot_memory_select, 1);
    chk({pad_out[4], pad_oe_n[4]}, 2'b10);
    chk(periph_in.lin_rxd, 0);
    chk(pad_oe_n[5], 1);
    for (int i = 0; i < 4; i++) begin
      wr(A_PORT, {11'h0, 2'(i), 1'b1, 2'b0, 16'hFFFF});
      chk({pad_out[tx[i]], pad_oe_n[tx[i]], gpio_in[tx[i]]}, 3'b100);
      chk(pad_oe_n[rx[i]], 1);
      wr(A_PORT, {8'h0, 2'(i), 1'b1, 5'h0, 16'hFFFF});
      chk({pad_oe_n[scl[i]], pad_oe_n[sda[i]]}, 2'b01);
    end
    wr(A_PORT, 32'h0001_FFFF);
    chk({pad_out[3], pad_out[1], pad_out[0], gpio_in[0]}, 4'b1010);
    wr(A_PORT, 32'h0007_FFFF);
    chk({pad_out[12], pad_out[10], pad_out[9]}, 3'b101);
    // USART receive on pad 3 must win over SPI clock on the same pad.
    wr(A_PORT, 32'h000D_FFFF);
    chk({pad_out[3], pad_oe_n[3]}, 2'b11);
    apb(1'b1, A_INFO, 32'h0, 4'hF);
    chk(err, 1);
    apb(1'b0, 32'h4000_000C, 32'h0, 4'h0);
    chk(err, 1);
    @(posedge pclk);
    meminfo_data <= {4'h5, 11'h123, 8'h34, 8'h56};
    meminfo_load <= 1'b1;
    @(posedge pclk);
    meminfo_load <= 1'b0;
    meminfo_data <= '0;
    rd_chk(A_INFO, 32'h5123_3456);
    chk({rd[7:0], 9'h000}, 32'h0000_AC00);
    chk({rd[26:16], 2'b00}, 32'h0000_048C);
    give_verdict();
  end
endmodule : system_config_pinmux_meminfo_test
